// ---- fault_regs.sv ----
// Power-profile registers C and D, sticky alarm flags, mask, lane flags and summary.
// Assumes a decoded register port from the serial control port, all on mclk_i.
`timescale 1ns/100ps
module fault_regs (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        soft_reset_i,
  // Register port
  input  wire logic [14:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Alarm sources
  input  wire logic [7:0]  lane_fifo_err_i,
  input  wire logic        spll_locked_i,
  input  wire logic        link_enable_i,
  input  wire logic        data_transmission_state_i,
  input  wire logic        mode_64b66b_i,
  input  wire logic        link_realign_i,
  input  wire logic        sysref_realign_i,
  input  wire logic        divider_mismatch_i,
  // Status pin routing
  input  wire logic        pin_sel_alarm_i,
  input  wire logic        cal_status_i,
  output logic             status_output_pin_o,
  // Profile outputs
  output logic      [7:0]  profile_field_c_o,
  output logic      [7:0]  profile_field_d_o,
  output logic             profile_low_power_o,
  output logic             fault_summary_o
);

  logic [7:0] power_profile_c_r;
  logic [7:0] power_profile_d_r;
  logic [7:0] fault_flags_r;
  logic [7:0] fault_flags_nxt;
  logic [7:0] fault_mask_r;
  logic [7:0] lane_faults_r;
  logic [7:0] lane_faults_nxt;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] lane_clr;
  logic [7:0] rdata_nxt;
  logic       link_en_q_r;
  logic       link_start;
  logic       summary;
  logic       pin_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Profile registers; reserved codes are stored as written
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      power_profile_c_r <= fault_regs_pkg::RST_PROFILE_C;
      power_profile_d_r <= fault_regs_pkg::RST_PROFILE_D;
    end else if (soft_reset_i) begin
      power_profile_c_r <= fault_regs_pkg::RST_PROFILE_C;
      power_profile_d_r <= fault_regs_pkg::RST_PROFILE_D;
    end else if (reg_wr_i) begin
      if (reg_addr_i == fault_regs_pkg::ADDR_PROFILE_C) begin
        power_profile_c_r <= reg_wdata_i;
      end
      if (reg_addr_i == fault_regs_pkg::ADDR_PROFILE_D) begin
        power_profile_d_r <= reg_wdata_i;
      end
    end
  end

  assign profile_field_c_o = power_profile_c_r;
  assign profile_field_d_o = power_profile_d_r;
  // Both fields must agree; software owns the rate and calibration ordering
  assign profile_low_power_o = (power_profile_c_r == fault_regs_pkg::LP_PROFILE_C) &&
                               (power_profile_d_r == fault_regs_pkg::LP_PROFILE_D);

  // Link start edge for the 64b66b alarm
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      link_en_q_r <= 1'b0;
    end else begin
      link_en_q_r <= link_enable_i;
    end
  end
  assign link_start = link_enable_i & ~link_en_q_r;

  // Alarm set conditions, one per flag except reserved bit 1
  always_comb begin
    flag_set                                 = 8'h00;
    flag_set[fault_regs_pkg::BIT_FIFO]       = |lane_fifo_err_i;
    flag_set[fault_regs_pkg::BIT_SPLL]       = ~spll_locked_i;
    if (mode_64b66b_i) begin
      flag_set[fault_regs_pkg::BIT_LINK]     = link_start | link_realign_i;
    end else begin
      flag_set[fault_regs_pkg::BIT_LINK]     = link_enable_i & ~data_transmission_state_i;
    end
    flag_set[fault_regs_pkg::BIT_REALIGN]    = sysref_realign_i;
    flag_set[fault_regs_pkg::BIT_CLK]        = divider_mismatch_i;
  end

  // Write-one-to-clear; a set in the same cycle wins over the clear
  always_comb begin
    flag_clr = 8'h00;
    lane_clr = 8'h00;
    if (reg_wr_i && reg_addr_i == fault_regs_pkg::ADDR_FLAGS) begin
      flag_clr = reg_wdata_i & fault_regs_pkg::FLAGS_IMPL;
      if (reg_wdata_i[fault_regs_pkg::BIT_FIFO]) begin
        lane_clr = 8'hff;
      end
    end
    if (reg_wr_i && reg_addr_i == fault_regs_pkg::ADDR_LANE) begin
      lane_clr = reg_wdata_i;
    end
    fault_flags_nxt = (fault_flags_r & ~flag_clr) | flag_set;
    lane_faults_nxt = (lane_faults_r & ~lane_clr) | lane_fifo_err_i;
  end

  // Sticky flag storage; reserved bit 1 only clears
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_flags_r <= fault_regs_pkg::RST_FLAGS;
      lane_faults_r <= fault_regs_pkg::RST_LANE;
    end else if (soft_reset_i) begin
      fault_flags_r <= fault_regs_pkg::RST_FLAGS;
      lane_faults_r <= fault_regs_pkg::RST_LANE;
    end else begin
      fault_flags_r <= fault_flags_nxt;
      lane_faults_r <= lane_faults_nxt;
    end
  end

  // Mask register; all bits plain read/write
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_mask_r <= fault_regs_pkg::RST_MASK;
    end else if (soft_reset_i) begin
      fault_mask_r <= fault_regs_pkg::RST_MASK;
    end else if (reg_wr_i && reg_addr_i == fault_regs_pkg::ADDR_MASK) begin
      fault_mask_r <= reg_wdata_i;
    end
  end

  // Summary recomputed each cycle so clears and masks act at once
  assign summary = |(fault_flags_r & ~fault_mask_r & fault_regs_pkg::FLAGS_ALARM);
  assign fault_summary_o = summary;

  // Status pin registered to keep it glitch free toward the board
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_sel_alarm_i ? summary : cal_status_i;
    end
  end
  assign status_output_pin_o = pin_r;

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr_i)
      fault_regs_pkg::ADDR_PROFILE_C: rdata_nxt = power_profile_c_r;
      fault_regs_pkg::ADDR_PROFILE_D: rdata_nxt = power_profile_d_r;
      fault_regs_pkg::ADDR_SUMMARY:   rdata_nxt = {7'h00, summary};
      fault_regs_pkg::ADDR_FLAGS:     rdata_nxt = fault_flags_r;
      fault_regs_pkg::ADDR_MASK:      rdata_nxt = fault_mask_r;
      fault_regs_pkg::ADDR_LANE:      rdata_nxt = lane_faults_r;
      default:                        rdata_nxt = 8'h00;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // Checks
  a_fifo_flag_set: assert property (
    (|lane_fifo_err_i && !soft_reset_i) |=> fault_flags_r[5])
    else $error("fifo flag not set");
  a_pll_flag_set: assert property (
    (!spll_locked_i && !soft_reset_i) |=> fault_flags_r[4])
    else $error("pll flag not set");
  a_link8_flag_set: assert property (
    (!mode_64b66b_i && link_enable_i && !data_transmission_state_i && !soft_reset_i)
      |=> fault_flags_r[3])
    else $error("link flag not set in 8b10b");
  a_link64_start_flag: assert property (
    (mode_64b66b_i && !link_en_q_r && link_enable_i && !soft_reset_i) |=> fault_flags_r[3])
    else $error("link start flag not set in 64b66b");
  a_realign_flag_set: assert property (
    (sysref_realign_i && !soft_reset_i) |=> fault_flags_r[2])
    else $error("realign flag not set");
  a_clk_flag_set: assert property (
    (divider_mismatch_i && !soft_reset_i) |=> fault_flags_r[0])
    else $error("clock flag not set");
  a_w1c_clears_clk: assert property (
    (reg_wr_i && reg_addr_i == 15'h02c1 && reg_wdata_i[0] && !divider_mismatch_i
      && !soft_reset_i) |=> !fault_flags_r[0])
    else $error("write one did not clear");
  a_w0_keeps_flag: assert property (
    (fault_flags_r[2] && !soft_reset_i && !(reg_wr_i && reg_addr_i == 15'h02c1
      && reg_wdata_i[2])) |=> fault_flags_r[2])
    else $error("flag lost without clear");
  a_soft_reset_vals: assert property (
    soft_reset_i |=> (fault_flags_r == 8'h3f && fault_mask_r == 8'h3f
      && power_profile_c_r == 8'h04 && power_profile_d_r == 8'h1b))
    else $error("soft reset values wrong");
  a_summary_readback: assert property (
    (reg_rd_i && reg_addr_i == 15'h02c0) |=> reg_rdata_o == {7'h00, $past(summary)})
    else $error("summary readback wrong");
  a_mask_blocks: assert property (
    (fault_mask_r == 8'h3f) |-> !fault_summary_o)
    else $error("masked flag reached summary");
  a_pin_routing: assert property (
    pin_sel_alarm_i |=> status_output_pin_o == $past(summary))
    else $error("summary not on status pin");
  a_lane_clear_all: assert property (
    (reg_wr_i && reg_addr_i == 15'h02c1 && reg_wdata_i[5] && lane_fifo_err_i == 8'h00
      && !soft_reset_i) |=> lane_faults_r == 8'h00)
    else $error("lane flags not cleared");

  c_summary_rises: cover property ($rose(fault_summary_o));
  c_set_during_clear: cover property (
    reg_wr_i && reg_addr_i == 15'h02c1 && reg_wdata_i[0] && divider_mismatch_i);
  c_low_power: cover property ($rose(profile_low_power_o));
  c_pin_alarm: cover property (pin_sel_alarm_i && status_output_pin_o);

endmodule

// ---- fault_regs_pkg.sv ----
// Constants for the power-profile and alarm register block.
// Assumes one register port driven by the serial control port decoder.
// How it works
// - Profile C: 0x00 low power, 0x04 reset
// - Profile D: 0x14 low power, 0x1b reset
// - Summary bit 0 = any unmasked flag set, reserved bit 1 excluded
// - Summary routed to status pin when selected
// - Bit 5 set on lane FIFO error
// - Bit 4 set while serializer PLL unlocked
// - 8b10b: bit 3 while enabled, not transmitting
// - 64b66b: bit 3 on start or realign
// - Bit 2 set on SYSREF clock realign
// - Bit 0 set on divider mismatch
// - Flags sticky, write one clears
// - Any reset sets flags to 0x3f
// - Mask bits 5:0 reset one, block summary
// - Lane bits sticky, cleared individually or together
package fault_regs_pkg;
  // Register port geometry
  localparam int          ADDR_W         = 15;
  localparam int          DATA_W         = 8;
  localparam int          LANES          = 8;
  // Register offsets
  localparam logic [14:0] ADDR_PROFILE_C = 15'h029b;
  localparam logic [14:0] ADDR_PROFILE_D = 15'h029c;
  localparam logic [14:0] ADDR_SUMMARY   = 15'h02c0;
  localparam logic [14:0] ADDR_FLAGS     = 15'h02c1;
  localparam logic [14:0] ADDR_MASK      = 15'h02c2;
  localparam logic [14:0] ADDR_LANE      = 15'h02c4;
  // Reset and profile values
  localparam logic [7:0]  RST_PROFILE_C  = 8'h04;
  localparam logic [7:0]  LP_PROFILE_C   = 8'h00;
  localparam logic [7:0]  RST_PROFILE_D  = 8'h1b;
  localparam logic [7:0]  LP_PROFILE_D   = 8'h14;
  localparam logic [7:0]  RST_FLAGS      = 8'h3f;
  localparam logic [7:0]  RST_MASK       = 8'h3f;
  localparam logic [7:0]  RST_LANE       = 8'hff;
  // Flag layout
  localparam logic [7:0]  FLAGS_IMPL     = 8'h3f;
  localparam logic [7:0]  FLAGS_ALARM    = 8'h3d;
  localparam int          BIT_FIFO       = 5;
  localparam int          BIT_SPLL       = 4;
  localparam int          BIT_LINK       = 3;
  localparam int          BIT_REALIGN    = 2;
  localparam int          BIT_CLK        = 0;
endpackage

// ---- tb_alarm_and_power_profile_regs.sv ----
// Self-checking bench for the power-profile and alarm register block.
// Assumes fault_regs and fault_regs_pkg are compiled before this file.
`timescale 1ns/100ps
module tb_alarm_and_power_profile_regs;
  // Clock, reset and register port
  logic        mclk_i                    = 1'b0;
  logic        rst_i                     = 1'b1;
  logic        soft_reset_i              = 1'b0;
  logic [14:0] reg_addr_i                = 15'h0000;
  logic        reg_wr_i                  = 1'b0;
  logic        reg_rd_i                  = 1'b0;
  logic [7:0]  reg_wdata_i               = 8'h00;
  logic [7:0]  reg_rdata_o;
  // Alarm sources, pin and profile outputs
  logic [7:0]  lane_fifo_err_i           = 8'h00;
  logic        spll_locked_i             = 1'b1;
  logic        link_enable_i             = 1'b0;
  logic        data_transmission_state_i = 1'b0;
  logic        mode_64b66b_i             = 1'b0;
  logic        link_realign_i            = 1'b0;
  logic        sysref_realign_i          = 1'b0;
  logic        divider_mismatch_i        = 1'b0;
  logic        pin_sel_alarm_i           = 1'b0;
  logic        cal_status_i              = 1'b0;
  logic        status_output_pin_o;
  logic [7:0]  profile_field_c_o;
  logic [7:0]  profile_field_d_o;
  logic        profile_low_power_o;
  logic        fault_summary_o;
  int          mismatches                = 0;
  int          n_compared                = 0;
  // Rows: address, write flag, write data, expected read
  logic [31:0] rows [13] = '{
    {15'h029b, 1'b0, 8'h00, 8'h04}, {15'h029c, 1'b0, 8'h00, 8'h1b},
    {15'h02c1, 1'b0, 8'h00, 8'h3f}, {15'h02c2, 1'b0, 8'h00, 8'h3f},
    {15'h02c4, 1'b0, 8'h00, 8'hff}, {15'h02c0, 1'b0, 8'h00, 8'h00},
    {15'h029b, 1'b1, 8'h00, 8'h00}, {15'h029c, 1'b1, 8'h14, 8'h14},
    {15'h02c1, 1'b1, 8'h3f, 8'h00}, {15'h02c4, 1'b0, 8'h00, 8'h00},
    {15'h02c3, 1'b1, 8'h55, 8'h00}, {15'h02c2, 1'b1, 8'h00, 8'h00},
    {15'h02c0, 1'b0, 8'h00, 8'h00}};
  // Flag bit each source should set, in source order
  logic [7:0]  bits [7] = '{8'h20, 8'h10, 8'h08, 8'h08, 8'h08, 8'h04, 8'h01};

  fault_regs DUT (
    .mclk_i, .rst_i, .soft_reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .lane_fifo_err_i, .spll_locked_i, .link_enable_i,
    .data_transmission_state_i, .mode_64b66b_i, .link_realign_i, .sysref_realign_i,
    .divider_mismatch_i, .pin_sel_alarm_i, .cal_status_i, .status_output_pin_o,
    .profile_field_c_o, .profile_field_d_o, .profile_low_power_o, .fault_summary_o);

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write strobe held for exactly one taking edge
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // Read data lands at the taking edge and is sampled just after it
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, reg_rdata_o);
  endtask

  // Drive one alarm source active or idle; mode stays 64b66b once entered
  task automatic src(input int k, input logic v);
    @(posedge mclk_i);
    case (k)
      0: lane_fifo_err_i <= v ? 8'h04 : 8'h00;
      1: spll_locked_i <= !v;
      2: link_enable_i <= v;
      3: begin
        mode_64b66b_i <= 1'b1;
        link_enable_i <= v;
      end
      4: link_realign_i <= v;
      5: sysref_realign_i <= v;
      default: divider_mismatch_i <= v;
    endcase
  endtask

  // Hang guard
  initial begin
    #1000000;
    mismatches++;
    results();
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][16]) wr(rows[i][31:17], rows[i][15:8]);
      rd(rows[i][31:17], rows[i][7:0]);
    end
    chk("low power", 8'h01, {7'h00, profile_low_power_o});
    chk("field c", 8'h00, profile_field_c_o);
    chk("field d", 8'h14, profile_field_d_o);
    // Each source sets its own sticky bit, write one clears it
    for (int k = 0; k < 7; k++) begin
      src(k, 1'b1);
      src(k, 1'b0);
      rd(fault_regs_pkg::ADDR_FLAGS, bits[k]);
      chk("summary set", 8'h01, {7'h00, fault_summary_o});
      wr(fault_regs_pkg::ADDR_FLAGS, bits[k]);
      rd(fault_regs_pkg::ADDR_FLAGS, 8'h00);
      chk("summary clear", 8'h00, {7'h00, fault_summary_o});
    end
    // Masked flag stays out of the summary until unmasked
    wr(fault_regs_pkg::ADDR_MASK, 8'h20);
    src(0, 1'b1);
    src(0, 1'b0);
    #1;
    chk("summary masked", 8'h00, {7'h00, fault_summary_o});
    rd(fault_regs_pkg::ADDR_LANE, 8'h04);
    wr(fault_regs_pkg::ADDR_LANE, 8'h04);
    rd(fault_regs_pkg::ADDR_LANE, 8'h00);
    // Pin follows the summary, then the calibration status, one cycle late
    @(posedge mclk_i);
    pin_sel_alarm_i <= 1'b1;
    wr(fault_regs_pkg::ADDR_MASK, 8'h00);
    chk("summary unmasked", 8'h01, {7'h00, fault_summary_o});
    @(posedge mclk_i);
    #1;
    chk("pin alarm", 8'h01, {7'h00, status_output_pin_o});
    @(posedge mclk_i);
    pin_sel_alarm_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk("pin cal low", 8'h00, {7'h00, status_output_pin_o});
    @(posedge mclk_i);
    cal_status_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk("pin cal high", 8'h01, {7'h00, status_output_pin_o});
    // A persisting condition sets the flag again over the clear
    @(posedge mclk_i);
    divider_mismatch_i <= 1'b1;
    wr(fault_regs_pkg::ADDR_FLAGS, 8'h21);
    rd(fault_regs_pkg::ADDR_FLAGS, 8'h01);
    @(posedge mclk_i);
    divider_mismatch_i <= 1'b0;
    wr(fault_regs_pkg::ADDR_FLAGS, 8'h01);
    rd(fault_regs_pkg::ADDR_FLAGS, 8'h00);
    // 8b10b link flag stays clear while the link sends data
    @(posedge mclk_i);
    mode_64b66b_i             <= 1'b0;
    data_transmission_state_i <= 1'b1;
    link_enable_i             <= 1'b1;
    wr(fault_regs_pkg::ADDR_FLAGS, 8'h3f);
    rd(fault_regs_pkg::ADDR_FLAGS, 8'h00);
    @(posedge mclk_i);
    data_transmission_state_i <= 1'b0;
    rd(fault_regs_pkg::ADDR_FLAGS, 8'h08);
    // Soft reset restores flags and profiles
    @(posedge mclk_i);
    link_enable_i <= 1'b0;
    soft_reset_i  <= 1'b1;
    @(posedge mclk_i);
    soft_reset_i  <= 1'b0;
    rd(fault_regs_pkg::ADDR_FLAGS, 8'h3f);
    rd(fault_regs_pkg::ADDR_PROFILE_C, 8'h04);
    chk("low power off", 8'h00, {7'h00, profile_low_power_o});
    chk("field d reset", 8'h1b, profile_field_d_o);
    // Mid-run power-on reset after a full low-power profile
    wr(fault_regs_pkg::ADDR_PROFILE_C, 8'h00);
    wr(fault_regs_pkg::ADDR_PROFILE_D, 8'h14);
    chk("low power again", 8'h01, {7'h00, profile_low_power_o});
    @(posedge mclk_i);
    rst_i <= 1'b1;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(fault_regs_pkg::ADDR_PROFILE_D, 8'h1b);
    rd(fault_regs_pkg::ADDR_FLAGS, 8'h3f);
    chk("field c reset", 8'h04, profile_field_c_o);
    results();
  end
endmodule
